// >>> jisp_pkg.sv
package jisp_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam logic [3:0] INS_ENABLE = 4'h9;
  localparam logic [3:0] INS_ERASE = 4'ha;
  localparam logic [3:0] INS_PROGRAM = 4'hb;
  localparam logic [3:0] INS_VERIFY = 4'hc;
  localparam logic [3:0] INS_BYPASS = 4'hf;
  localparam logic [3:0] INS_IDCODE = 4'h1;
  localparam int unsigned ROW_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned ISR_W = ROW_W + ADDR_W;
  // Pulse widths as printed, least times
  localparam int unsigned PWE_MS = 100;
  localparam int unsigned PWP_MS = 10;
  localparam int unsigned PWV_US = 10;
  localparam int unsigned ERASE_CYC = PWE_MS * (CLK_HZ / 1000);
  localparam int unsigned PROG_CYC = PWP_MS * (CLK_HZ / 1000);
  localparam int unsigned VERIFY_CYC = PWV_US * (CLK_HZ / 1_000_000);
  // Arbitrary identification value
  localparam logic [31:0] ID_RESET = 32'h0000_1001;
  typedef enum logic [3:0] {
    JISP_RESET = 4'h0, JISP_IDLE = 4'h1, JISP_SEL_DR = 4'h2, JISP_CAP_DR = 4'h3,
    JISP_SH_DR = 4'h4, JISP_EX1_DR = 4'h5, JISP_PAU_DR = 4'h6, JISP_EX2_DR = 4'h7,
    JISP_UPD_DR = 4'h8, JISP_SEL_IR = 4'h9, JISP_CAP_IR = 4'ha, JISP_SH_IR = 4'hb,
    JISP_EX1_IR = 4'hc, JISP_PAU_IR = 4'hd, JISP_EX2_IR = 4'he, JISP_UPD_IR = 4'hf
  } jisp_tap_t;
endpackage : jisp_pkg

// >>> jisp_array.sv
`timescale 1ns/100ps
// Row memory of the configuration array; read data come from a register
module jisp_array #(
  parameter int unsigned AW = 4,
  parameter int unsigned DW = 16
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic wr,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule : jisp_array

// >>> jisp_top.sv
`timescale 1ns/100ps
module jisp_top
  import jisp_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_CYC,
  parameter int unsigned PROG_CYCLES = PROG_CYC,
  parameter int unsigned VERIFY_CYCLES = VERIFY_CYC,
  parameter logic [31:0] ID_VALUE = ID_RESET
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_o,
  output logic tdo_oe_n,
  // User logic
  input wire logic [7:0] user_out,
  input wire logic [7:0] user_verify_val,
  output logic [7:0] pin_out,
  output logic isp_busy,
  output logic pump_on
);
  // ----------------------------------------------------------------
  // Pin synchronisers and test clock edges
  // ----------------------------------------------------------------
  logic [1:0] tck_s, tms_s, tdi_s;
  logic tck_q;
  logic tck_rise, tck_fall;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      // Test clock rests low, so start at that level to avoid a false edge
      tck_s <= 2'h0;
      tms_s <= 2'h3;
      tdi_s <= 2'h3;
      tck_q <= 1'b0;
    end else if (clk_en) begin
      tck_s <= {tck_s[0], tck};
      tms_s <= {tms_s[0], tms};
      tdi_s <= {tdi_s[0], tdi};
      tck_q <= tck_s[1];
    end
  end

  assign tck_rise = clk_en && tck_s[1] && !tck_q;
  assign tck_fall = clk_en && !tck_s[1] && tck_q;

  // ----------------------------------------------------------------
  // Port controller
  // ----------------------------------------------------------------
  jisp_tap_t tap, next_tap;
  logic t;

  always_comb begin
    t = tms_s[1];
    unique case (tap)
      JISP_RESET: next_tap = t ? JISP_RESET : JISP_IDLE;
      JISP_IDLE: next_tap = t ? JISP_SEL_DR : JISP_IDLE;
      JISP_SEL_DR: next_tap = t ? JISP_SEL_IR : JISP_CAP_DR;
      JISP_CAP_DR: next_tap = t ? JISP_EX1_DR : JISP_SH_DR;
      JISP_SH_DR: next_tap = t ? JISP_EX1_DR : JISP_SH_DR;
      JISP_EX1_DR: next_tap = t ? JISP_UPD_DR : JISP_PAU_DR;
      JISP_PAU_DR: next_tap = t ? JISP_EX2_DR : JISP_PAU_DR;
      JISP_EX2_DR: next_tap = t ? JISP_UPD_DR : JISP_SH_DR;
      JISP_UPD_DR: next_tap = t ? JISP_SEL_DR : JISP_IDLE;
      JISP_SEL_IR: next_tap = t ? JISP_RESET : JISP_CAP_IR;
      JISP_CAP_IR: next_tap = t ? JISP_EX1_IR : JISP_SH_IR;
      JISP_SH_IR: next_tap = t ? JISP_EX1_IR : JISP_SH_IR;
      JISP_EX1_IR: next_tap = t ? JISP_UPD_IR : JISP_PAU_IR;
      JISP_PAU_IR: next_tap = t ? JISP_EX2_IR : JISP_PAU_IR;
      JISP_EX2_IR: next_tap = t ? JISP_UPD_IR : JISP_SH_IR;
      JISP_UPD_IR: next_tap = t ? JISP_SEL_DR : JISP_IDLE;
    endcase
  end

  // Power-up reset stands in for the missing test reset pin
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tap <= JISP_RESET;
    end else if (tck_rise) begin
      tap <= next_tap;
    end
  end

  // ----------------------------------------------------------------
  // Instruction register and unlock
  // ----------------------------------------------------------------
  logic [3:0] ir_sh, ir;
  logic unlocked;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ir_sh <= 4'h0;
      ir <= INS_IDCODE;
    end else if (tck_rise) begin
      if (tap == JISP_CAP_IR) begin
        ir_sh <= 4'h1;
      end else if (tap == JISP_SH_IR) begin
        ir_sh <= {tdi_s[1], ir_sh[3:1]};
      end
      if (tap == JISP_RESET) begin
        ir <= INS_IDCODE;
      end else if (tap == JISP_UPD_IR) begin
        ir <= ir_sh;
      end
    end
  end

  // Unlock survives later instructions; only the reset state drops it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      unlocked <= 1'b0;
    end else if (tck_rise) begin
      if (tap == JISP_RESET) begin
        unlocked <= 1'b0;
      end else if (tap == JISP_UPD_IR && ir_sh == INS_ENABLE) begin
        unlocked <= 1'b1;
      end
    end
  end

  logic isp_sel;
  assign isp_sel = unlocked && (ir == INS_ENABLE || ir == INS_ERASE ||
                                ir == INS_PROGRAM || ir == INS_VERIFY);

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  logic [31:0] op_cnt;
  logic erasing, programming, verifying;
  logic [ADDR_W:0] erase_row;
  logic [ROW_W+ADDR_W-1:0] isr;
  logic [ROW_W-1:0] rd_data;
  logic arr_wr;
  logic [ADDR_W-1:0] arr_addr;
  logic [ROW_W-1:0] arr_wdata;
  logic start_op;

  // Operation starts when run state is entered after loading the code
  assign start_op = tck_rise && tap == JISP_UPD_DR && !tms_s[1] && isp_sel &&
                    !isp_busy;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      erasing <= 1'b0;
      programming <= 1'b0;
      verifying <= 1'b0;
      op_cnt <= 32'h0;
      erase_row <= '0;
    end else if (clk_en) begin
      if (start_op) begin
        erasing <= (ir == INS_ERASE);
        programming <= (ir == INS_PROGRAM);
        verifying <= (ir == INS_VERIFY);
        op_cnt <= 32'h0;
        erase_row <= '0;
      end else if (isp_busy) begin
        op_cnt <= op_cnt + 32'h1;
        if (erasing && !erase_row[ADDR_W]) begin
          erase_row <= erase_row + 1'b1;
        end
        if ((erasing && op_cnt + 32'h1 >= ERASE_CYCLES) ||
            (programming && op_cnt + 32'h1 >= PROG_CYCLES) ||
            (verifying && op_cnt + 32'h1 >= VERIFY_CYCLES)) begin
          erasing <= 1'b0;
          programming <= 1'b0;
          verifying <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      isp_busy <= 1'b0;
      pump_on <= 1'b0;
    end else if (clk_en) begin
      isp_busy <= erasing || programming || verifying || start_op;
      pump_on <= (erasing || programming) && isp_busy;
    end
  end

  // Whole array is walked row by row inside the single erase pulse
  assign arr_wr = clk_en && ((erasing && !erase_row[ADDR_W]) ||
                  (programming && op_cnt == 32'h0));
  assign arr_addr = erasing ? erase_row[ADDR_W-1:0] : isr[ADDR_W-1:0];
  assign arr_wdata = erasing ? '0 : isr[ISR_W-1:ADDR_W];

  jisp_array #(.AW(ADDR_W), .DW(ROW_W)) u_array (
    .clk(ref_clk),
    .ce(clk_en),
    .wr(arr_wr),
    .addr(arr_addr),
    .wdata(arr_wdata),
    .rdata(rd_data)
  );

  // ----------------------------------------------------------------
  // Data registers: ISP shift, bypass, identification
  // ----------------------------------------------------------------
  logic byp;
  logic [31:0] idr;
  logic cap_row;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_row <= 1'b0;
    end else if (clk_en) begin
      cap_row <= verifying && op_cnt == 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      isr <= '0;
    end else if (cap_row && clk_en) begin
      isr <= {rd_data, isr[ADDR_W-1:0]};
    end else if (tck_rise && tap == JISP_SH_DR && isp_sel) begin
      isr <= {tdi_s[1], isr[ISR_W-1:1]};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      byp <= 1'b0;
      idr <= 32'h0;
    end else if (tck_rise) begin
      if (tap == JISP_CAP_DR) begin
        byp <= 1'b0;
        idr <= ID_VALUE;
      end else if (tap == JISP_SH_DR) begin
        byp <= tdi_s[1];
        idr <= {tdi_s[1], idr[31:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Data out on falling edge, floating when not shifting
  // ----------------------------------------------------------------
  logic so;

  always_comb begin
    if (tap == JISP_SH_IR) begin
      so = ir_sh[0];
    end else if (isp_sel) begin
      so = isr[0];
    end else if (ir == INS_IDCODE) begin
      so = idr[0];
    end else begin
      so = byp;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tdo_o <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo_o <= so;
      tdo_oe_n <= !(tap == JISP_SH_DR || tap == JISP_SH_IR);
    end
  end

  // ----------------------------------------------------------------
  // User pins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= 8'h00;
    end else if (clk_en) begin
      pin_out <= verifying ? user_verify_val : user_out;
    end
  end
endmodule : jisp_top

// >>> jisp_props.sv
`timescale 1ns/100ps
module jisp_props
  import jisp_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_CYC,
  parameter int unsigned PROG_CYCLES = PROG_CYC,
  parameter int unsigned VERIFY_CYCLES = VERIFY_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Test port
  input wire logic tck,
  input wire logic tdo_o,
  input wire logic tdo_oe_n,
  // User side
  input wire logic [7:0] user_out,
  input wire logic [7:0] user_verify_val,
  input wire logic [7:0] pin_out,
  input wire logic isp_busy,
  input wire logic pump_on
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  int unsigned busy_len;
  int unsigned pump_len;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) busy_len <= 0;
    else busy_len <= isp_busy ? busy_len + 1 : 0;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) pump_len <= 0;
    else pump_len <= pump_on ? pump_len + 1 : 0;
  end
  sequence verify_run;
    (isp_busy && !pump_on) ##1 (isp_busy && !pump_on);
  endsequence
  sequence user_run;
    !isp_busy ##1 !isp_busy;
  endsequence
  a_reset_idle: assert property ($rose(arst_n) |-> !isp_busy && !pump_on && tdo_oe_n)
    else $error("outputs not idle after reset");
  a_pin_verify: assert property (verify_run |-> pin_out == $past(user_verify_val))
    else $error("pins not in user state during verify");
  a_pin_normal: assert property (user_run |-> pin_out == $past(user_out))
    else $error("pins not following user logic");
  a_pump_busy: assert property (pump_on |-> isp_busy)
    else $error("pump on without operation");
  a_tdo_fall: assert property ($changed(tdo_o) |-> !$past(tck, 2))
    else $error("data out moved away from falling clock");
  a_oe_fall: assert property ($changed(tdo_oe_n) |-> !$past(tck, 2))
    else $error("output enable moved away from falling clock");
  a_busy_min: assert property ($fell(isp_busy) |-> busy_len >= VERIFY_CYCLES)
    else $error("operation too short");
  a_pump_min: assert property ($fell(pump_on) |-> pump_len >= PROG_CYCLES)
    else $error("write pulse too short");
  a_busy_max: assert property (isp_busy |-> busy_len <= ERASE_CYCLES + 4)
    else $error("operation never ends");
endmodule : jisp_props
bind jisp_top jisp_props #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES),
  .VERIFY_CYCLES(VERIFY_CYCLES)) i_jisp_props (.ref_clk(ref_clk), .arst_n(arst_n), .tck(tck),
  .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .user_out(user_out), .user_verify_val(user_verify_val),
  .pin_out(pin_out), .isp_busy(isp_busy), .pump_on(pump_on));

// >>> jisp_host.sv
`timescale 1ns/100ps
module jisp_host (
  // Bench clock
  input wire logic ref_clk,
  // Test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe_n
);
  // Lines rest at their pull-up level; the clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // 400 ns period keeps well under the clock limit
  // Eight system clocks a test clock period; lines move just after a clock edge
  task automatic step(input logic ms, input logic di, output logic obit);
    tms <= ms;
    tdi <= di;
    repeat (4) @(posedge ref_clk);
    obit = tdo_o;
    tck <= 1'b1;
    repeat (4) @(posedge ref_clk);
    tck <= 1'b0;
  endtask : step
  // Each frame starts on a system clock edge
  task automatic reset_tap();
    logic b;
    @(posedge ref_clk);
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask : reset_tap
  task automatic scan(input logic ir, input logic [31:0] val, input int n, output logic [31:0] got);
    logic b;
    got = '0;
    @(posedge ref_clk);
    step(1'b1, 1'b1, b);
    if (ir) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, val[i], b);
      got[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask : scan
endmodule : jisp_host

// >>> jtag_isp_eeprom_programmer_test.sv
`timescale 1ns/100ps
module jtag_isp_eeprom_programmer_test;
  import jisp_pkg::*;
  // Arbitrary identification value
  localparam logic [31:0] ID_TB = 32'h0000_0a5b;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] user_out = 8'h00;
  logic [7:0] user_verify_val = 8'h00;
  logic tck, tms, tdi, tdo_o, tdo_oe_n, isp_busy, pump_on, busy_q;
  logic [7:0] pin_out;
  logic [31:0] seed = 32'ha1ed990d;
  logic [31:0] got;
  logic [3:0] addr_tab [4] = '{4'h0, 4'hf, 4'h6, 4'h9};
  logic [15:0] data_tab [4];
  int err_total = 0;
  int checks = 0;
  int busy_rises = 0;
  always #25 ref_clk = ~ref_clk;
  jisp_top #(.ERASE_CYCLES(40), .PROG_CYCLES(20), .VERIFY_CYCLES(4), .ID_VALUE(ID_TB)) i_jisp_top (
    .ref_clk, .arst_n, .clk_en(1'b1), .tck, .tms, .tdi, .tdo_o, .tdo_oe_n,
    .user_out, .user_verify_val, .pin_out, .isp_busy, .pump_on);
  jisp_host i_jisp_host (.ref_clk, .tck, .tms, .tdi, .tdo_o, .tdo_oe_n);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0);
  endfunction : lfsr
  // Fresh user values every cycle so the pin multiplexer is exercised
  always @(posedge ref_clk) begin
    seed <= lfsr(seed);
    user_out <= seed[7:0];
    user_verify_val <= seed[15:8];
    busy_q <= isp_busy;
    if (isp_busy === 1'b1 && busy_q === 1'b0) busy_rises <= busy_rises + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  // Instruction scan, data scan, then wait out the operation
  task automatic run_op(input logic [3:0] ins, input logic [31:0] val, input int fire);
    int n0;
    n0 = busy_rises;
    i_jisp_host.scan(1'b1, {28'h0, ins}, 4, got);
    i_jisp_host.scan(1'b0, val, 20, got);
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 200 && isp_busy !== 1'b0; i++) @(posedge ref_clk);
    chk(32'(busy_rises - n0), 32'(fire));
  endtask : run_op
  task automatic read_row(input logic [3:0] a, input logic [15:0] d);
    run_op(INS_VERIFY, {16'h0, a}, 1);
    run_op(INS_VERIFY, {16'h0, a}, 1);
    chk(got[19:0], {d, a});
  endtask : read_row
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    i_jisp_host.reset_tap();
    i_jisp_host.scan(1'b0, 32'h0, 32, got);
    chk(got, ID_TB);
    chk(32'(tdo_oe_n), 32'h1);
    i_jisp_host.scan(1'b1, {28'h0, INS_BYPASS}, 4, got);
    i_jisp_host.scan(1'b0, 32'h0000_00b5, 8, got);
    chk(got[7:0], 8'h6a);
    i_jisp_host.scan(1'b1, {28'h0, INS_IDCODE}, 4, got);
    i_jisp_host.scan(1'b0, 32'h0, 32, got);
    chk(got, ID_TB);
    run_op(INS_ERASE, 32'h0, 0);
    run_op(INS_PROGRAM, 32'h0001_2345, 0);
    run_op(INS_VERIFY, 32'h5, 0);
    i_jisp_host.scan(1'b1, {28'h0, INS_ENABLE}, 4, got);
    for (int k = 0; k < 4; k++) begin
      data_tab[k] = (k == 1) ? 16'hffff : seed[27:12];
      run_op(INS_PROGRAM, {12'h0, data_tab[k], addr_tab[k]}, 1);
    end
    for (int k = 0; k < 4; k++) read_row(addr_tab[k], data_tab[k]);
    run_op(INS_ERASE, 32'h0, 1);
    read_row(4'h0, 16'h0000);
    read_row(4'hf, 16'h0000);
    i_jisp_host.reset_tap();
    run_op(INS_PROGRAM, 32'h0001_2343, 0);
    test_done();
  end
  initial begin
    #2_000_000;
    err_total++;
    test_done();
  end
endmodule : jtag_isp_eeprom_programmer_test
